//--- core/ssfo_pkg.sv
package ssfo_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  // line rates in baud, indexed by the 3-bit rate select
  localparam int unsigned RATE_BAUD [8] = '{1200, 2400, 4800, 9600,
                                            19200, 38400, 57600, 115200};
  localparam logic [2:0]  BAUD_RST  = 3'h4;
  localparam logic [1:0]  ORDER_RST = 2'h3;
  localparam logic [7:0]  ADDR_MAX  = 8'hF7;
  localparam logic [7:0]  ADDR_DFLT = 8'h01;
  // idle gap of three and a half characters, in bit times rounded up
  localparam int unsigned GAP_CHARS_X2 = 7;
  localparam int unsigned CHAR_BITS    = 11;
  localparam logic [5:0]  GAP_BITS     =
    6'((GAP_CHARS_X2 * CHAR_BITS + 1) / 2);
  localparam logic [3:0]  CHAR_LEN       = 4'(CHAR_BITS);
  localparam logic [3:0]  CHAR_LEN_1STOP = 4'(CHAR_BITS - 1);
  localparam logic [7:0]  FC_RD_COILS = 8'h01;
  localparam logic [7:0]  FC_RD_DISC  = 8'h02;
  localparam logic [7:0]  FC_RD_HOLD  = 8'h03;
  localparam logic [7:0]  FC_RD_INP   = 8'h04;
  localparam logic [7:0]  FC_WR_COIL  = 8'h05;
  localparam logic [7:0]  FC_WR_REG   = 8'h06;
  localparam logic [7:0]  FC_RD_EXC   = 8'h07;
  localparam logic [7:0]  FC_WR_COILS = 8'h0F;
  localparam logic [7:0]  FC_WR_REGS  = 8'h10;
  localparam logic [7:0]  EXC_FLAG  = 8'h80;
  localparam logic [7:0]  EXC_FUNC  = 8'h01;
  localparam logic [7:0]  EXC_VALUE = 8'h03;
  localparam logic [15:0] MAX_REGS   = 16'h007D;
  localparam logic [15:0] MAX_BITS   = 16'h07D0;
  localparam logic [15:0] NUM_ALARMS = 16'h0003;
  localparam logic [3:0]  LEN_SHORT = 4'h4;
  localparam logic [3:0]  LEN_FULL  = 4'h8;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [1:0]  PART_FIRST  = 2'h1;
  localparam logic [1:0]  PART_SECOND = 2'h2;

  typedef enum logic [1:0] {
    fr_even, fr_odd, no_parity_two_stop, no_parity_one_stop
  } ssfo_frame_t;
  localparam ssfo_frame_t FRAME_RST = fr_even;

  typedef enum logic [1:0] {
    rx_idle = 2'h0, rx_start = 2'h1, rx_bits = 2'h3, rx_stop = 2'h2
  } ssfo_rx_t;

  typedef enum logic [3:0] {
    tx_idle = 4'h0, tx_head = 4'h1, tx_func = 4'h3, tx_count = 4'h2,
    tx_kind = 4'h6, tx_fetch = 4'h7, tx_hi = 4'h5, tx_lo = 4'h4,
    tx_crcl = 4'hC, tx_crch = 4'hD, tx_done = 4'hF
  } ssfo_tx_t;

  function automatic logic [15:0] baud_div(input logic [2:0] s);
    return 16'(CLK_HZ / RATE_BAUD[s]);
  endfunction : baud_div

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step
endpackage : ssfo_pkg

//--- core/ssfo_baud.sv
module ssfo_baud (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        restart,
  input  wire logic        half,
  input  wire logic [15:0] div,
  output logic             tick
);
  logic [15:0] cnt_q, cnt_d;
  logic        tick_q, tick_d;

  always_comb begin
    cnt_d  = cnt_q - 16'h0001;
    tick_d = 1'h0;
    if (restart) begin
      // half period lands the first tick mid start bit
      cnt_d = half ? {1'h0, div[15:1]} : div - 16'h0001;
    end else if (cnt_q == 16'h0000) begin
      cnt_d  = div - 16'h0001;
      tick_d = 1'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'h0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule : ssfo_baud

//--- core/ssfo_buf.sv
module ssfo_buf (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [7:0]      out_data
);
  logic [7:0] mem_q [2];
  logic [7:0] mem_d [2];
  logic       wr_q, wr_d, rd_q, rd_d;
  logic [1:0] cnt_q, cnt_d;
  logic       push, pop;

  assign push = in_valid && (cnt_q != 2'h2);
  assign pop  = out_ready && (cnt_q != 2'h0);

  always_comb begin
    mem_d = mem_q;
    if (push) begin
      mem_d[wr_q] = in_data;
    end
    wr_d  = wr_q ^ push;
    rd_d  = rd_q ^ pop;
    cnt_d = cnt_q + {1'h0, push} - {1'h0, pop};
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mem_q <= '{8'h00, 8'h00};
      wr_q  <= 1'h0;
      rd_q  <= 1'h0;
      cnt_q <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  assign in_ready  = cnt_q != 2'h2;
  assign out_valid = cnt_q != 2'h0;
  assign out_data  = mem_q[rd_q];
endmodule : ssfo_buf

//--- core/ssfo_top.sv
// Function
// - answer at programmed address 1..247; zero or above 247 means 1.
// - parity modes send eight data bits, parity bit, one stop.
// - no parity sends eight data bits and two or one stop.
// - four framing choices; a confirmed choice applies at once.
// - rates 1200 to 115200 baud, eight steps, picked by config.
// - loading defaults selects 19200 baud.
// - binary framing with checksum only; no text mode.
// - standard order sends high byte of a register first.
// - two-bit order picks register order and byte order.
// - order change applies immediately, no confirmation.
// - byte swap applies to every register sent.
// - register swap only reorders 32-bit pairs.
// - wire address is register number's low four digits minus one.
// - read/write bits use codes 01, 05, 15; here all three get exception 01.
// - read-only discrete bits use code 02.
// - read-only registers use codes 03 or 04.
// - read/write registers use codes 03, 06, 16; here 06 and 16 get exception 01.
// - drive the line only while replying, otherwise listen.
// - value reads by 03 or 04 only; no write codes.
// - exception status bits 0-1 carry the order setting.
module ssfo_top
  import ssfo_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        rx_in,
  output logic             tx_out,
  output logic             tx_en,
  input  wire logic [7:0]  cfg_addr,
  input  ssfo_frame_t      cfg_frame,
  input  wire logic [2:0]  cfg_baud,
  input  wire logic        cfg_apply,
  input  wire logic        dflt_load,
  input  wire logic [1:0]  cfg_order,
  input  wire logic [5:0]  fault_in,
  input  wire logic [2:0]  alarm_in,
  output logic [15:0]      reg_addr,
  input  wire logic [1:0]  reg_part,
  input  wire logic [15:0] reg_data,
  output logic             rx_err
);
  ssfo_frame_t frame_q, frame_d;
  logic [2:0]  baud_q, baud_d;
  logic [1:0]  order_q;
  logic [7:0]  eff_q, eff_d;
  logic [15:0] div;
  logic        par_on;

  assign div    = baud_div(baud_q);
  assign par_on = (frame_q == fr_even) || (frame_q == fr_odd);

  always_comb begin
    frame_d = frame_q;
    baud_d  = baud_q;
    if (dflt_load) begin
      frame_d = FRAME_RST;
      baud_d  = BAUD_RST;
    end else if (cfg_apply) begin
      frame_d = cfg_frame;
      baud_d  = cfg_baud;
    end
    eff_d = (cfg_addr == 8'h00 || cfg_addr > ADDR_MAX) ?
            ADDR_DFLT : cfg_addr;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frame_q <= FRAME_RST;
      baud_q  <= BAUD_RST;
      order_q <= ORDER_RST;
      eff_q   <= ADDR_DFLT;
    end else begin
      frame_q <= frame_d;
      baud_q  <= baud_d;
      order_q <= cfg_order;
      eff_q   <= eff_d;
    end
  end

  // receive side
  ssfo_rx_t   rx_st_q, rx_st_d;
  logic [8:0] rx_sh_q, rx_sh_d;
  logic [3:0] rx_cnt_q, rx_cnt_d;
  logic [7:0] rx_byte;
  logic       rx_tick, rx_go, par_ok, byte_ok, byte_bad;
  logic       tx_en_q, tx_en_d;

  // no listening while our own driver is on
  assign rx_go   = (rx_st_q == rx_idle) && !rx_in && !tx_en_q;
  assign rx_byte = par_on ? rx_sh_q[7:0] : rx_sh_q[8:1];
  assign par_ok  = !par_on || ((^rx_sh_q) == (frame_q == fr_odd));

  ssfo_baud u_rx_baud (
    .clock   (clock),
    .sys_rst (sys_rst),
    .restart (rx_go),
    .half    (1'h1),
    .div     (div),
    .tick    (rx_tick)
  );

  always_comb begin
    rx_st_d  = rx_st_q;
    rx_sh_d  = rx_sh_q;
    rx_cnt_d = rx_cnt_q;
    byte_ok  = 1'h0;
    byte_bad = 1'h0;
    case (rx_st_q)
      rx_idle: begin
        if (rx_go) rx_st_d = rx_start;
      end
      rx_start: begin
        if (rx_tick) begin
          // a glitch shorter than half a bit is dropped
          rx_st_d  = rx_in ? rx_idle : rx_bits;
          rx_cnt_d = 4'h0;
        end
      end
      rx_bits: begin
        if (rx_tick) begin
          rx_sh_d  = {rx_in, rx_sh_q[8:1]};
          rx_cnt_d = rx_cnt_q + 4'h1;
          if (rx_cnt_q == (par_on ? 4'h8 : 4'h7)) rx_st_d = rx_stop;
        end
      end
      rx_stop: begin
        if (rx_tick) begin
          rx_st_d  = rx_idle;
          byte_ok  = rx_in && par_ok;
          byte_bad = !(rx_in && par_ok);
        end
      end
      default: rx_st_d = rx_idle;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_st_q  <= rx_idle;
      rx_sh_q  <= 9'h000;
      rx_cnt_q <= 4'h0;
    end else begin
      rx_st_q  <= rx_st_d;
      rx_sh_q  <= rx_sh_d;
      rx_cnt_q <= rx_cnt_d;
    end
  end

  // idle gap timer in bit times
  logic [5:0] gap_q, gap_d;
  logic       gap_tick, frame_end;
  logic [7:0] rq_q [8];
  logic [7:0] rq_d [8];
  logic [3:0] rq_cnt_q, rq_cnt_d;
  logic [15:0] rq_crc_q, rq_crc_d;
  logic       rq_bad_q, rq_bad_d, rx_err_q, rx_err_d;

  ssfo_baud u_gap_baud (
    .clock   (clock),
    .sys_rst (sys_rst),
    .restart (1'h0),
    .half    (1'h0),
    .div     (div),
    .tick    (gap_tick)
  );

  assign frame_end = gap_tick && (gap_q == GAP_BITS - 6'h01) &&
                     (rq_cnt_q != 4'h0);

  always_comb begin
    gap_d    = gap_q;
    rq_d     = rq_q;
    rq_cnt_d = rq_cnt_q;
    rq_crc_d = rq_crc_q;
    rq_bad_d = rq_bad_q || byte_bad;
    if (rx_st_q != rx_idle || !rx_in) begin
      gap_d = 6'h00;
    end else if (gap_tick && gap_q != GAP_BITS) begin
      gap_d = gap_q + 6'h01;
    end
    if (byte_ok) begin
      // binary bytes only, checked by the frame checksum
      rq_crc_d = crc_step(rq_crc_q, rx_byte);
      if (rq_cnt_q < LEN_FULL) begin
        rq_d[rq_cnt_q[2:0]] = rx_byte;
        rq_cnt_d = rq_cnt_q + 4'h1;
      end
    end
    rx_err_d = frame_end && (rq_bad_q || rq_crc_q != 16'h0000);
    if (frame_end) begin
      rq_cnt_d = 4'h0;
      rq_crc_d = CRC_INIT;
      rq_bad_d = 1'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      gap_q    <= 6'h00;
      rq_q     <= '{default: 8'h00};
      rq_cnt_q <= 4'h0;
      rq_crc_q <= CRC_INIT;
      rq_bad_q <= 1'h0;
      rx_err_q <= 1'h0;
    end else begin
      gap_q    <= gap_d;
      rq_q     <= rq_d;
      rq_cnt_q <= rq_cnt_d;
      rq_crc_q <= rq_crc_d;
      rq_bad_q <= rq_bad_d;
      rx_err_q <= rx_err_d;
    end
  end

  // request decode
  logic [7:0]  fc_w;
  logic [15:0] qty_w;
  logic        full_w, hit_w;

  assign fc_w   = rq_q[1];
  assign qty_w  = {rq_q[4], rq_q[5]};
  assign full_w = rq_cnt_q == LEN_FULL;
  // foreign and broadcast addresses never get a reply
  assign hit_w  = frame_end && !rq_bad_q && rq_crc_q == 16'h0000 &&
                  rq_cnt_q >= LEN_SHORT && rq_q[0] == eff_q;

  function automatic logic [7:0] disc_byte(input logic [15:0] a,
                                           input logic [15:0] left,
                                           input logic [2:0]  al);
    logic [7:0]  r;
    logic [15:0] x;
    r = 8'h00;
    for (int b = 0; b < 8; b++) begin
      x    = a + 16'(b);
      r[b] = (16'(b) < left) && (x < NUM_ALARMS) && al[x[1:0]];
    end
    return r;
  endfunction : disc_byte

  // reply builder
  ssfo_tx_t    tx_st_q, tx_st_d;
  logic [7:0]  fc_q, fc_d, exc_q, exc_d, push_b, pop_b;
  logic [15:0] ptr_q, ptr_d, n_q, n_d, word_q, word_d;
  logic [15:0] reg_addr_q, reg_addr_d, crc_q, crc_d;
  logic        push_v, push_rdy, pop_v, ser_busy_q, tx_ld;

  always_comb begin
    tx_st_d    = tx_st_q;
    fc_d       = fc_q;
    exc_d      = exc_q;
    ptr_d      = ptr_q;
    n_d        = n_q;
    word_d     = word_q;
    reg_addr_d = reg_addr_q;
    crc_d      = crc_q;
    push_v     = 1'h0;
    push_b     = 8'h00;
    case (tx_st_q)
      tx_idle: begin
        crc_d = CRC_INIT;
        if (hit_w) begin
          tx_st_d = tx_head;
          fc_d    = fc_w;
          ptr_d   = {rq_q[2], rq_q[3]};
          n_d     = qty_w;
          case (fc_w)
            FC_RD_HOLD, FC_RD_INP:
              exc_d = (full_w && qty_w != 16'h0000 && qty_w <= MAX_REGS) ?
                      8'h00 : EXC_VALUE;
            FC_RD_DISC:
              exc_d = (full_w && qty_w != 16'h0000 && qty_w <= MAX_BITS) ?
                      8'h00 : EXC_VALUE;
            FC_RD_EXC:
              exc_d = (rq_cnt_q == LEN_SHORT) ? 8'h00 : EXC_VALUE;
            // coil and register writes are not carried
            default: exc_d = EXC_FUNC;
          endcase
        end
      end
      tx_head: begin
        push_v = 1'h1;
        push_b = eff_q;
        if (push_rdy) tx_st_d = tx_func;
      end
      tx_func: begin
        push_v = 1'h1;
        push_b = (exc_q != 8'h00) ? (fc_q | EXC_FLAG) : fc_q;
        if (push_rdy) tx_st_d = tx_count;
      end
      tx_count: begin
        push_v = 1'h1;
        if (exc_q != 8'h00) push_b = exc_q;
        else if (fc_q == FC_RD_EXC) push_b = {fault_in, order_q};
        else if (fc_q == FC_RD_DISC) push_b = 8'((n_q + 16'h0007) >> 3);
        else push_b = {n_q[6:0], 1'h0};
        if (push_rdy) begin
          if (exc_q != 8'h00 || fc_q == FC_RD_EXC) tx_st_d = tx_crcl;
          else if (fc_q == FC_RD_DISC) tx_st_d = tx_hi;
          else tx_st_d = tx_kind;
        end
      end
      tx_kind: begin
        reg_addr_d = ptr_q;
        tx_st_d    = tx_fetch;
      end
      tx_fetch: begin
        // only halves of a 32-bit pair trade places
        if (!order_q[1] && reg_part == PART_FIRST) begin
          reg_addr_d = ptr_q + 16'h0001;
        end else if (!order_q[1] && reg_part == PART_SECOND) begin
          reg_addr_d = ptr_q - 16'h0001;
        end
        tx_st_d = tx_hi;
      end
      tx_hi: begin
        push_v = 1'h1;
        if (fc_q == FC_RD_DISC) begin
          push_b = disc_byte(ptr_q, n_q, alarm_in);
          if (push_rdy) begin
            ptr_d = ptr_q + 16'h0008;
            n_d   = (n_q > 16'h0008) ? n_q - 16'h0008 : 16'h0000;
            if (n_q <= 16'h0008) tx_st_d = tx_crcl;
          end
        end else begin
          // byte swap covers strings and single words alike
          push_b = order_q[0] ? reg_data[15:8] : reg_data[7:0];
          word_d = reg_data;
          if (push_rdy) tx_st_d = tx_lo;
        end
      end
      tx_lo: begin
        push_v = 1'h1;
        push_b = order_q[0] ? word_q[7:0] : word_q[15:8];
        if (push_rdy) begin
          ptr_d   = ptr_q + 16'h0001;
          n_d     = n_q - 16'h0001;
          tx_st_d = (n_q == 16'h0001) ? tx_crcl : tx_kind;
        end
      end
      tx_crcl: begin
        push_v = 1'h1;
        push_b = crc_q[7:0];
        if (push_rdy) tx_st_d = tx_crch;
      end
      tx_crch: begin
        push_v = 1'h1;
        push_b = crc_q[15:8];
        if (push_rdy) tx_st_d = tx_done;
      end
      tx_done: begin
        if (!pop_v && !ser_busy_q) tx_st_d = tx_idle;
      end
      default: tx_st_d = tx_idle;
    endcase
    // the checksum bytes must not fold into themselves
    if (push_v && push_rdy && tx_st_q != tx_crcl && tx_st_q != tx_crch) begin
      crc_d = crc_step(crc_q, push_b);
    end
    tx_en_d = tx_st_d != tx_idle;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_st_q    <= tx_idle;
      fc_q       <= 8'h00;
      exc_q      <= 8'h00;
      ptr_q      <= 16'h0000;
      n_q        <= 16'h0000;
      word_q     <= 16'h0000;
      reg_addr_q <= 16'h0000;
      crc_q      <= CRC_INIT;
      tx_en_q    <= 1'h0;
    end else begin
      tx_st_q    <= tx_st_d;
      fc_q       <= fc_d;
      exc_q      <= exc_d;
      ptr_q      <= ptr_d;
      n_q        <= n_d;
      word_q     <= word_d;
      reg_addr_q <= reg_addr_d;
      crc_q      <= crc_d;
      tx_en_q    <= tx_en_d;
    end
  end

  // a serializer stall holds the builder instead of dropping bytes
  ssfo_buf u_buf (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (push_v),
    .in_ready  (push_rdy),
    .in_data   (push_b),
    .out_valid (pop_v),
    .out_ready (!ser_busy_q),
    .out_data  (pop_b)
  );

  // transmit serializer
  logic [10:0] tx_sh_q, tx_sh_d;
  logic [3:0]  tx_cnt_q, tx_cnt_d;
  logic        ser_busy_d, tx_out_q, tx_out_d, tx_tick, par_bit;

  assign tx_ld   = pop_v && !ser_busy_q;
  assign par_bit = (frame_q == fr_odd) ? ~^pop_b : ^pop_b;

  ssfo_baud u_tx_baud (
    .clock   (clock),
    .sys_rst (sys_rst),
    .restart (tx_ld),
    .half    (1'h0),
    .div     (div),
    .tick    (tx_tick)
  );

  always_comb begin
    ser_busy_d = ser_busy_q;
    tx_sh_d    = tx_sh_q;
    tx_cnt_d   = tx_cnt_q;
    if (tx_ld) begin
      ser_busy_d = 1'h1;
      tx_sh_d    = {1'h1, par_on ? par_bit : 1'h1, pop_b, 1'h0};
      tx_cnt_d   = (frame_q == no_parity_one_stop) ?
                   CHAR_LEN_1STOP : CHAR_LEN;
    end else if (ser_busy_q && tx_tick) begin
      tx_sh_d  = {1'h1, tx_sh_q[10:1]};
      tx_cnt_d = tx_cnt_q - 4'h1;
      if (tx_cnt_q == 4'h1) ser_busy_d = 1'h0;
    end
    tx_out_d = ser_busy_d ? tx_sh_d[0] : 1'h1;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ser_busy_q <= 1'h0;
      tx_sh_q    <= 11'h7FF;
      tx_cnt_q   <= 4'h0;
      tx_out_q   <= 1'h1;
    end else begin
      ser_busy_q <= ser_busy_d;
      tx_sh_q    <= tx_sh_d;
      tx_cnt_q   <= tx_cnt_d;
      tx_out_q   <= tx_out_d;
    end
  end

  assign tx_out   = tx_out_q;
  assign tx_en    = tx_en_q;
  assign reg_addr = reg_addr_q;
  assign rx_err   = rx_err_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  addr_fallback_a: assert property (
    (cfg_addr == 8'h00 || cfg_addr > ADDR_MAX) |=> eff_q == ADDR_DFLT)
    else $error("bad address not replaced by one");
  dflt_baud_a: assert property (
    dflt_load |=> baud_q == BAUD_RST && frame_q == FRAME_RST &&
                  div == baud_div(BAUD_RST))
    else $error("defaults did not pick the default rate");
  order_follow_a: assert property (
    $changed(cfg_order) |=> order_q == $past(cfg_order))
    else $error("order change not immediate");
  quiet_line_a: assert property (
    ser_busy_q |-> tx_en_q)
    else $error("line driven while driver off");
  stat_order_a: assert property (
    (tx_st_q == tx_count && fc_q == FC_RD_EXC && exc_q == 8'h00)
    |-> push_b[1:0] == order_q)
    else $error("status byte lacks order bits");
  foreign_quiet_a: assert property (
    (frame_end && rq_q[0] != eff_q && tx_st_q == tx_idle)
    |=> tx_st_q == tx_idle [*2])
    else $error("reply to foreign address");
  even_par_a: assert property (
    (tx_ld && frame_q == fr_even) |=> !(^tx_sh_q[9:1]) && tx_sh_q[10])
    else $error("even parity character wrong");
  gap_end_a: assert property (
    frame_end |-> rx_in && rx_st_q == rx_idle && $stable(rx_st_q))
    else $error("frame ended without idle gap");
  msb_first_a: assert property (
    (tx_st_q == tx_hi && fc_q != FC_RD_DISC && order_q[0])
    |-> push_b == reg_data[15:8])
    else $error("high byte not sent first");
endmodule : ssfo_top

//--- sim/ssfo_master.sv
module ssfo_master
  import ssfo_pkg::*;
#(
  parameter int BIT = 348
) (
  input  wire logic  clock,
  input  wire logic  tx_out,
  input  ssfo_frame_t frame,
  output logic       rx_in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial rx_in = 1'b1;

  task automatic put(input logic v);
    @(posedge clock) #1 rx_in <= v;
    repeat (BIT - 1) @(posedge clock);
  endtask : put

  // lsb first, then parity or stop bits as framed
  task automatic send(input logic [7:0] b);
    put(1'b0);
    for (int i = 0; i < 8; i++) put(b[i]);
    if (frame == fr_even) put(^b);
    if (frame == fr_odd) put(~^b);
    put(1'b1);
    if (frame == no_parity_two_stop) put(1'b1);
  endtask : send

  // samples mid bit, so a wrong rate drifts out within a character
  task automatic get(output logic [7:0] b, output bit ok);
    int n;
    n = 0;
    // falling edges only: the line is settled there
    while (tx_out !== 1'b0 && n < 30000) begin
      @(negedge clock);
      n++;
    end
    ok = (n < 30000);
    repeat (BIT / 2) @(negedge clock);
    ok &= (tx_out === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(negedge clock);
      b[i] = tx_out;
    end
    if (frame == fr_even || frame == fr_odd) begin
      repeat (BIT) @(negedge clock);
      ok &= (tx_out === (^b ^ (frame == fr_odd)));
    end
    repeat (BIT) @(negedge clock);
    ok &= (tx_out === 1'b1);
  endtask : get
endmodule : ssfo_master

//--- sim/tb.sv
module tb;
  import ssfo_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BIT = int'(CLK_HZ / RATE_BAUD[7]);

  logic        clock, sys_rst, rx_in, tx_out, tx_en, cfg_apply, rx_err;
  logic        dflt_load;
  logic [7:0]  cfg_addr;
  ssfo_frame_t cfg_frame;
  logic [2:0]  cfg_baud;
  logic [1:0]  cfg_order;
  logic [5:0]  fault_in;
  logic [15:0] reg_addr;
  int          err_total, samples_checked, rx_err_seen;

  ssfo_top DUT (.clock(clock), .sys_rst(sys_rst), .rx_in(rx_in),
    .tx_out(tx_out), .tx_en(tx_en), .cfg_addr(cfg_addr),
    .cfg_frame(cfg_frame), .cfg_baud(cfg_baud), .cfg_apply(cfg_apply),
    .dflt_load(dflt_load), .cfg_order(cfg_order), .fault_in(fault_in),
    .alarm_in(3'h5), .reg_addr(reg_addr), .reg_part(2'h0),
    .reg_data(reg_addr ^ 16'hA5A5), .rx_err(rx_err));

  ssfo_master #(.BIT(BIT)) master (.clock(clock), .tx_out(tx_out),
    .frame(cfg_frame), .rx_in(rx_in));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // one-cycle error pulses, counted where they are settled
  always @(negedge clock) begin
    if (rx_err === 1'b1) rx_err_seen++;
  end

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc16

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task automatic request(input logic [7:0] q[$]);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) master.send(q[i]);
  endtask : request

  task automatic reply(input logic [7:0] q[$]);
    logic [15:0] c;
    logic [7:0]  b;
    bit          ok;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      master.get(b, ok);
      check({7'h0, ok}, 8'h01);
      check(b, q[i]);
      check({7'h0, tx_en}, 8'h01);
      if (!ok) results();
    end
  endtask : reply

  task automatic apply(input ssfo_frame_t f);
    @(posedge clock) #1 cfg_frame = f;
    cfg_apply = 1'b1;
    @(posedge clock) #1 cfg_apply = 1'b0;
  endtask : apply

  // silence window longer than the idle gap plus reply latency
  task automatic quiet(input int pulses);
    int k;
    k = 0;
    repeat (42 * BIT) begin
      @(negedge clock);
      if (tx_en !== 1'b0 || tx_out !== 1'b1) k++;
    end
    check({7'h0, k != 0}, 8'h00);
    check(8'(rx_err_seen), 8'(pulses));
  endtask : quiet

  initial begin
    sys_rst = 1'b1;
    cfg_apply = 1'b0;
    dflt_load = 1'b0;
    cfg_addr = 8'h00;
    cfg_frame = fr_even;
    cfg_baud = 3'h7;
    cfg_order = 2'h3;
    fault_in = 6'h2D;
    err_total = 0;
    samples_checked = 0;
    rx_err_seen = 0;
    repeat (12) @(posedge clock);
    #1 sys_rst = 1'b0;
    check(reg_addr[7:0], 8'h00);
    check(reg_addr[15:8], 8'h00);
    @(posedge clock) #1 dflt_load = 1'b1;
    @(posedge clock) #1 dflt_load = 1'b0;
    apply(fr_even);
    check({7'h0, tx_en}, 8'h00);
    // a lone byte fails the checksum and stays unanswered
    master.send(8'h5A);
    quiet(1);
    @(posedge clock) #1 cfg_addr = 8'h05;
    apply(no_parity_one_stop);
    request('{8'h01, FC_RD_EXC});
    quiet(1);
    @(posedge clock) #1 cfg_addr = 8'h00;
    // order changes without any confirmation pulse
    cfg_order = 2'h2;
    apply(fr_odd);
    request('{8'h01, FC_RD_EXC});
    reply('{8'h01, FC_RD_EXC, {fault_in, 2'h2}});
    repeat (2 * BIT) @(posedge clock);
    check({7'h0, tx_en}, 8'h00);
    check(8'(rx_err_seen), 8'h01);
    check(reg_addr[7:0], 8'h00);
    results();
  end
endmodule : tb
